// *** hdl/adsq_pkg.sv ***
package adsq_pkg;

  // ****************************************
  // register map (word index on the plain port)
  // ****************************************
  localparam logic [3:0] ADDR_CHSEL = 4'h0;
  localparam logic [3:0] ADDR_MODE = 4'h1;
  localparam logic [3:0] ADDR_RESULT = 4'h2;
  localparam logic [3:0] ADDR_PFMODE = 4'h3;
  localparam logic [3:0] ADDR_PFTHR = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;

  // ****************************************
  // field positions and widths
  // ****************************************
  localparam int CH_W = 3;
  localparam int RES_W = 10;
  localparam int MODE_CE_BIT = 0;
  localparam int MODE_FR_LO = 3;
  localparam int MODE_FR_HI = 5;
  localparam int MODE_CS_BIT = 7;
  localparam int PF_EN_BIT = 7;
  localparam int PF_CMP_BIT = 6;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_PF_BIT = 1;
  localparam int IRQ_W = 2;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CHSEL_RST = 8'h00;
  localparam logic [7:0] PFMODE_RST = 8'h00;
  localparam logic [7:0] PFTHR_RST = 8'h00;
  localparam logic [9:0] RESULT_RST = 10'h000;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // ****************************************
  // timing: conversion time per select code, in clocks
  // ****************************************
  localparam int CLK_MHZ = 50;
  localparam int STARTUP_EXTRA = 16;
  localparam int CONV_CYC_W = 10;
  localparam logic [CONV_CYC_W-1:0] CONV_CYC_TAB [8] = '{
    10'h3c0, 10'h300, 10'h240, 10'h180, 10'h0f0, 10'h0c0, 10'h090, 10'h060};

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adsq_bus_req_t;

  typedef struct packed {
    logic [9:0] value;
    logic done;
  } adsq_conv_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FIRST = 2'b01,
    ST_REPEAT = 2'b11
  } adsq_state_t;

endpackage

// *** hdl/adsq_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// conversion period counter: one done pulse per conversion
// ****************************************
module adsq_timer
  import adsq_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic [CONV_CYC_W-1:0] period,
  // event
  output logic tick
);

  logic [CONV_CYC_W-1:0] cnt_q;
  logic [CONV_CYC_W-1:0] cnt_d;
  wire at_end = run && (cnt_q + 10'h001 >= period);

  // restart on every end and hold at zero while stopped
  assign cnt_d = (!run || at_end) ? 10'h000 : cnt_q + 10'h001;
  assign tick = at_end;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cnt_q <= 10'h000;
    else
      cnt_q <= cnt_d;
  end

endmodule

`default_nettype wire

// *** hdl/adsq_core.sv ***
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - channel write costs one wait cycle
// - mode/channel write may spoil result
// - result read costs one wait cycle
// - power-fail mode write costs wait cycle
// - threshold write costs one wait cycle
// - first conversion lasts selected time plus settling tail
// - repeated pf conversions last selected time
// - converter stops in standby
// - result read beats end-of-conversion update
// - mode or channel write suppresses end-of-conversion update
module adsq_core
  import adsq_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_wait,
  // analog side
  input wire logic [9:0] sample_value,
  output logic [CH_W-1:0] analog_input_sel,
  output logic comparator_powered,
  // system
  input wire logic standby,
  output logic conversion_done_irq
);

  // ****************************************
  // register state
  // ****************************************
  logic [7:0] mode_q;
  logic [7:0] chsel_q;
  logic [7:0] pfmode_q;
  logic [7:0] pfthr_q;
  logic [RES_W-1:0] result_q;
  logic [RES_W-1:0] result_d;
  logic [RES_W-1:0] pend_q;
  logic pend_valid_q;
  logic [IRQ_W-1:0] stat_q;
  logic [IRQ_W-1:0] mask_q;
  logic [7:0] rdata_q;
  logic pf_flag_q;
  adsq_state_t state_q;
  adsq_state_t state_d;
  adsq_bus_req_t req;
  adsq_conv_t conv;
  logic [CONV_CYC_W-1:0] period;
  logic tick;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ****************************************
  // address decode
  // ****************************************
  wire wr_chsel = req.wr && req.addr == ADDR_CHSEL;
  wire wr_mode = req.wr && req.addr == ADDR_MODE;
  wire wr_pfmode = req.wr && req.addr == ADDR_PFMODE;
  wire wr_pfthr = req.wr && req.addr == ADDR_PFTHR;
  wire wr_stat = req.wr && req.addr == ADDR_IRQ_STAT;
  wire wr_mask = req.wr && req.addr == ADDR_IRQ_MASK;
  wire rd_result = req.rd && (req.addr == ADDR_RESULT);

  // wait cycle on the accesses that touch the converter's slow side
  // wait on channel, mode, pf mode and threshold writes and on result reads
  assign reg_wait = wr_chsel || rd_result || wr_pfmode || wr_pfthr || wr_mode;

  // ****************************************
  // mode fields
  // ****************************************
  wire conv_on = mode_q[MODE_CS_BIT] && !standby;
  wire [2:0] fr_sel = mode_q[MODE_FR_HI:MODE_FR_LO];
  wire pf_on = pfmode_q[PF_EN_BIT];
  // channel field only, upper bits ignored
  assign analog_input_sel = chsel_q[CH_W-1:0];
  assign comparator_powered = mode_q[MODE_CE_BIT] && !standby;

  // ****************************************
  // conversion sequencer
  // ****************************************
  // first conversion adds a settling tail, later ones use the selected time
  // selected conversion time, plus the settling tail while in ST_FIRST
  assign period = (state_q == ST_FIRST) ?
    CONV_CYC_TAB[fr_sel] + CONV_CYC_W'(STARTUP_EXTRA) : CONV_CYC_TAB[fr_sel];

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (conv_on) state_d = ST_FIRST;
      ST_FIRST: if (!conv_on) state_d = ST_IDLE; else if (tick) state_d = ST_REPEAT;
      ST_REPEAT: if (!conv_on) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  adsq_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(conv_on && state_q != ST_IDLE),
    .period(period),
    .tick(tick)
  );

  // a mode or channel write in the end cycle drops the new result
  wire blocked = wr_mode || wr_chsel;
  assign conv = '{value: sample_value, done: tick && !blocked};

  // read wins, result lands one cycle later
  wire take_pend = pend_valid_q && !rd_result;
  always_comb
  begin
    result_d = result_q;
    if (conv.done && !rd_result)
      result_d = conv.value;
    else if (take_pend)
      result_d = pend_q;
  end

  // threshold compare on upper 8 bits
  wire pf_hit = pfmode_q[PF_CMP_BIT] ? (conv.value[9:2] <= pfthr_q) : (conv.value[9:2] > pfthr_q);
  wire pf_event = pf_on && conv.done && pf_hit;
  wire [IRQ_W-1:0] ev = {pf_event, conv.done};

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      mode_q <= MODE_RST;
      chsel_q <= CHSEL_RST;
      pfmode_q <= PFMODE_RST;
      pfthr_q <= PFTHR_RST;
      mask_q <= IRQ_RST;
    end
    else
    begin
      if (wr_mode) mode_q <= req.wdata;
      if (wr_chsel) chsel_q <= req.wdata;
      if (wr_pfmode) pfmode_q <= req.wdata;
      if (wr_pfthr) pfthr_q <= req.wdata;
      if (wr_mask) mask_q <= req.wdata[IRQ_W-1:0];
    end
  end

  // result, deferred copy and compare flag
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      result_q <= RESULT_RST;
      pend_q <= RESULT_RST;
      pend_valid_q <= 1'b0;
      pf_flag_q <= 1'b0;
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
      result_q <= result_d;
      pend_valid_q <= (conv.done && rd_result) || (pend_valid_q && rd_result);
      if (conv.done) pend_q <= conv.value;
      if (conv.done && pf_on) pf_flag_q <= pf_hit;
    end
  end

  // ****************************************
  // interrupt status: set beats write-one-clear
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi++)
    begin : g_stat
      always_ff @(posedge mclk)
      begin
        if (!rst_n)
          stat_q[gi] <= 1'b0;
        else if (ev[gi])
          stat_q[gi] <= 1'b1;
        else if (wr_stat && req.wdata[gi])
          stat_q[gi] <= 1'b0;
      end
    end
  endgenerate

  assign conversion_done_irq = |(stat_q & mask_q);

  // ****************************************
  // read mux, data one cycle after the strobe
  // ****************************************
  logic [7:0] rd_mux;
  always_comb
  begin
    case (req.addr)
      ADDR_CHSEL: rd_mux = chsel_q;
      ADDR_MODE: rd_mux = mode_q;
      ADDR_RESULT: rd_mux = result_q[9:2];
      ADDR_PFMODE: rd_mux = pfmode_q;
      ADDR_PFTHR: rd_mux = pfthr_q;
      ADDR_IRQ_STAT: rd_mux = {6'h00, stat_q};
      ADDR_IRQ_MASK: rd_mux = {6'h00, mask_q};
      ADDR_STATUS: rd_mux = {5'h00, pf_flag_q, state_q};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      rdata_q <= 8'h00;
    else if (req.rd)
      rdata_q <= rd_mux;
    else
      rdata_q <= 8'h00;
  end
  assign reg_rdata = rdata_q;

  // ****************************************
  // checks
  // ****************************************
  // read wins
  read_priority_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (conv.done && rd_result) |=> (result_q == $past(result_q)) ##1 ($past(rd_result) || result_q == $past(pend_q)))
    else $error("result changed during colliding read");
  write_suppress_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (tick && blocked) |=> !stat_q[IRQ_DONE_BIT] || $past(stat_q[IRQ_DONE_BIT]))
    else $error("done flag set despite config write");
  chsel_wait_a: assert property (@(posedge mclk) disable iff (!rst_n) wr_chsel |-> reg_wait)
    else $error("no wait on channel write");
  result_wait_a: assert property (@(posedge mclk) disable iff (!rst_n) rd_result |-> reg_wait)
    else $error("no wait on result read");
  pfmode_wait_a: assert property (@(posedge mclk) disable iff (!rst_n) wr_pfmode |-> reg_wait)
    else $error("no wait on pf mode write");
  pfthr_wait_a: assert property (@(posedge mclk) disable iff (!rst_n) wr_pfthr |-> reg_wait)
    else $error("no wait on threshold write");
  standby_stop_a: assert property (@(posedge mclk) disable iff (!rst_n)
    standby ##1 standby |-> state_q == ST_IDLE && !comparator_powered)
    else $error("converter ran in standby");
  conv_time_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == ST_REPEAT && tick) |-> period == CONV_CYC_TAB[fr_sel])
    else $error("wrong repeat conversion time");
  pf_compare_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (conv.done && pf_on) |=> pf_flag_q == $past(pf_hit))
    else $error("power-fail flag mismatch");
  first_long_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == ST_FIRST |-> period > CONV_CYC_TAB[fr_sel])
    else $error("first conversion not lengthened");

  cov_done_c: cover property (@(posedge mclk) conv.done);
  cov_collide_c: cover property (@(posedge mclk) conv.done && rd_result);
  cov_block_c: cover property (@(posedge mclk) tick && blocked);
  cov_pf_c: cover property (@(posedge mclk) pf_event);

endmodule

`default_nettype wire

// *** tb/adsq_analog_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// analog source standing behind the channel mux
// ****************************************
module adsq_analog_model
  import adsq_pkg::*;
(
  // clock
  input wire logic mclk,
  // from the converter
  input wire logic [CH_W-1:0] analog_input_sel,
  input wire logic comparator_powered,
  // from the bench
  input wire logic [9:0] level,
  // to the converter
  output logic [9:0] sample_value
);
  logic [9:0] junk_q = 10'h2a5;

  // unpowered comparator gives garbage that changes every cycle, so a stale value never passes
  always @(posedge mclk) junk_q <= ~junk_q;

  // each channel reads the bench level plus its own index
  assign sample_value = comparator_powered ? level + {7'h00, analog_input_sel} : junk_q;
endmodule

`default_nettype wire

// *** tb/adc_sequencing_and_power_fail_compare_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module adc_sequencing_and_power_fail_compare_tb
  import adsq_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic standby = 1'b0;
  logic [9:0] level = 10'h000;
  logic [7:0] reg_rdata;
  logic reg_wait;
  logic [9:0] sample_value;
  logic [CH_W-1:0] sel;
  logic cpow;
  logic irq;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0, t1, t2;
  logic [7:0] d, x;
  logic [3:0] ra [4] = '{ADDR_CHSEL, ADDR_MODE, ADDR_PFTHR, ADDR_IRQ_MASK};
  logic [7:0] rm [4] = '{8'h07, 8'h39, 8'hff, 8'h03};

  // clock and cycle count
  always #10 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  adsq_core dut_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_wait(reg_wait),
    .sample_value(sample_value), .analog_input_sel(sel), .comparator_powered(cpow),
    .standby(standby), .conversion_done_irq(irq));

  adsq_analog_model src_u (.mclk(mclk), .analog_input_sel(sel), .comparator_powered(cpow),
    .level(level), .sample_value(sample_value));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic exp_wait(input logic [3:0] a, input logic w);
    return w ? (a == ADDR_CHSEL || a == ADDR_MODE || a == ADDR_PFMODE || a == ADDR_PFTHR) : a == ADDR_RESULT;
  endfunction

  task automatic end_sim();
    $display("counts: %0d compares, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one-cycle strobes; wait marker looked at inside the strobe cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(negedge mclk);
    chk("wr_wait", exp_wait(a, 1'b1), reg_wait);
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(negedge mclk);
    chk("rd_wait", exp_wait(a, 1'b0), reg_wait);
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    v = reg_rdata;
  endtask

  task automatic wait_irq(output int t);
    t = -1;
    for (int i = 0; i < 3000 && t < 0; i++)
    begin
      @(posedge mclk);
      if (irq === 1'b1)
        t = cyc;
    end
    chk("irq_seen", 1, t >= 0);
  endtask

  // full setup, first conversion, one repeat; pf threshold fixed at 0x80
  task automatic conv(input logic [2:0] fr, input logic [2:0] ch, input logic [9:0] lv, input logic pf,
    input logic cmp);
    logic [9:0] v;
    logic hit;
    logic o;
    v = lv + {7'h00, ch};
    hit = pf && (cmp ? v[9:2] <= 8'h80 : v[9:2] > 8'h80);
    o = 1'($urandom);
    wr(ADDR_MODE, 8'h00);
    level <= lv;
    wr(ADDR_PFTHR, 8'h80);
    wr(ADDR_PFMODE, {pf, cmp, 6'h00});
    wr(o ? ADDR_CHSEL : ADDR_MODE, o ? {5'h00, ch} : {2'b00, fr, 3'b001});
    wr(o ? ADDR_MODE : ADDR_CHSEL, o ? {2'b00, fr, 3'b001} : {5'h00, ch});
    @(negedge mclk);
    chk("chan_sel", ch, sel);
    chk("cmp_power", 1, cpow);
    repeat (700) @(posedge mclk);
    wr(ADDR_IRQ_MASK, 8'h03);
    wr(ADDR_IRQ_STAT, 8'h03);
    wr(ADDR_MODE, {2'b10, fr, 3'b001});
    t0 = cyc;
    wait_irq(t1);
    chk("first_long", 1, (t1 - t0) > CONV_CYC_TAB[fr]);
    rd(ADDR_RESULT, d);
    chk("result", v[9:2], d);
    rd(ADDR_IRQ_STAT, d);
    chk("irq_stat", {6'h00, hit, 1'b1}, d);
    rd(ADDR_STATUS, d);
    chk("state", 2'b11, d[1:0]);
    wr(ADDR_IRQ_STAT, 8'h03);
    wait_irq(t2);
    chk("period", CONV_CYC_TAB[fr], t2 - t1);
    wr(ADDR_MODE, 8'h00);
    $display("test conversion fr %0d pf %0d done", fr, pf);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    void'($urandom(57));
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++)
    begin
      rd(4'(a), d);
      chk("reset_val", 0, d);
    end
    wr(4'h9, 8'hff);
    rd(4'h9, d);
    chk("unmapped", 0, d);
    $display("test reset values done");
    for (int i = 0; i < 8; i++)
    begin
      x = 8'($urandom) & rm[i % 4];
      wr(ra[i % 4], x);
      rd(ra[i % 4], d);
      chk("readback", x, d);
    end
    $display("test readback done");
    conv(3'h0, 3'h7, 10'h3f8, 1'b0, 1'b0);
    conv(3'h7, 3'h0, 10'h000, 1'b0, 1'b0);
    for (int i = 0; i < 6; i++)
      conv(3'($urandom), 3'($urandom), (i < 2) ? 10'($urandom % 1008) : (1'($urandom) ? 10'h3c0 : 10'h040),
        i >= 2, 1'(i));
    // masking, clearing and standby stop
    wr(ADDR_IRQ_MASK, 8'h00);
    wr(ADDR_MODE, 8'h39);
    repeat (700) @(posedge mclk);
    wr(ADDR_IRQ_STAT, 8'h03);
    wr(ADDR_MODE, 8'hb9);
    repeat (200) @(posedge mclk);
    chk("masked_irq", 0, irq);
    // back-to-back result reads; the extra gap shifts phase so a read meets a conversion end
    x = 8'((level + {7'h00, sel}) >> 2);
    for (int i = 0; i < 200; i++)
    begin
      if (i % 7 == 0)
        @(posedge mclk);
      rd(ADDR_RESULT, d);
      chk("collide_result", x, d);
    end
    wr(ADDR_IRQ_MASK, 8'h01);
    @(negedge mclk);
    chk("unmasked_irq", 1, irq);
    @(posedge mclk);
    standby <= 1'b1;
    @(negedge mclk);
    chk("standby_power", 0, cpow);
    wr(ADDR_IRQ_STAT, 8'h03);
    @(negedge mclk);
    chk("cleared_irq", 0, irq);
    repeat (300) @(posedge mclk);
    rd(ADDR_IRQ_STAT, d);
    chk("standby_stop", 0, d);
    standby <= 1'b0;
    $display("test irq and standby done");
    end_sim();
  end

  // watchdog: the whole run needs well under 80000 clocks
  initial
  begin
    #1600000;
    n_fail++;
    end_sim();
  end
endmodule

`default_nettype wire
